// ===== design/pulse_and_waveform_sequencer.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Operation
// - Mode value 0 selects pulse mode
// - Mode value 1 selects waveform mode
// - Run mode: free, count or duration
// - Count or duration end stops all
// - One common period for all channels
// - Per-channel shape: DC, src1, src2, three-level
// - Three-level sums two independently timed sources
// - Store delay, width, leading per source; trailing fixed at 1
// - Store base/peak levels or DC level
// - Apply setup; drive base or initial
// - Start all channels together, lockstep sequences
// - Pulse stop returns to base level
// - Waveform stop returns to initial level
// - Pulse trigger at selected channel source 1 delay
// - Waveform trigger: sequence, change, pattern start
// - Store switch enable, rest, delay, hold
// - Apply per-vector switch state
// - 50 ns delay on pattern index change
// - Hold last level during change delay
// - Waveform command while running stops; free run restarts
// - Accept pattern and sequence data
// - Measure level, compute and store impedance
// - Status run one, wait zero
// - Vector: level, switch bit, time increment
module pulse_and_waveform_sequencer (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Measured terminal level, same clock
	input  wire logic [31:0] terminal_level,
	// Channel outputs
	output logic [1:0][31:0] channel_level,
	output logic [1:0]       pulse_switch_closed,
	output logic             trigger_out
);

	logic                         module_mode;
	logic [1:0]                   run_mode;
	logic                         trig_ch;
	logic                         trig_en;
	logic                         out_sw;
	logic [31:0]                  period;
	logic [31:0]                  count_limit;
	logic [31:0]                  duration;
	logic [1:0][1:0]              shape;
	pulse_seq_pkg::source_timing_type [1:0][1:0] timing;
	logic [1:0][1:0][31:0]        base_lvl;
	logic [1:0][1:0][31:0]        peak_lvl;
	logic                         sw_enable;
	logic                         sw_rest_closed;
	logic [15:0]                  sw_delay;
	logic [15:0]                  sw_hold;
	logic [1:0][31:0]             load_imp;
	logic [31:0]                  measured;
	pulse_seq_pkg::vector_type    vectors [pulse_seq_pkg::vector_depth];
	pulse_seq_pkg::seq_step_type  steps [pulse_seq_pkg::seq_depth];
	logic [3:0]                   seq_len;
	logic                         running;
	logic                         rerun;
	logic [31:0]                  period_cnt;
	logic [31:0]                  done_cnt;
	logic [31:0]                  elapsed;
	logic [2:0]                   step_idx;
	logic [31:0]                  rep_cnt;
	logic [3:0]                   vec_idx;
	logic [30:0]                  vec_cnt;
	logic [3:0]                   gap_cnt;
	logic                         seq_done;

	wire write_en = psel && penable && pwrite;
	wire cmd_wr   = write_en && paddr == pulse_seq_pkg::off_command;
	wire do_apply = cmd_wr && pwdata[pulse_seq_pkg::cmd_apply_pos];
	wire do_start = cmd_wr && pwdata[pulse_seq_pkg::cmd_start_pos];
	wire do_stop  = cmd_wr && pwdata[pulse_seq_pkg::cmd_stop_pos];
	wire do_seq   = cmd_wr && pwdata[pulse_seq_pkg::cmd_seq_pos];
	wire do_meas  = cmd_wr && pwdata[pulse_seq_pkg::cmd_meas_pos];
	wire ctl_wr   = write_en && paddr == pulse_seq_pkg::off_control;
	wire run_chg  = ctl_wr && pwdata[pulse_seq_pkg::ctl_run_mode_pos +: 2] != run_mode;
	wire sw_off   = ctl_wr && !pwdata[pulse_seq_pkg::ctl_out_sw_pos];
	wire wave_cmd = module_mode && running && (do_apply || do_seq || do_start);
	wire count_end = run_mode == pulse_seq_pkg::run_count && period_cnt == period - 32'h1
	                 && done_cnt + 32'h1 >= count_limit;
	wire dur_end   = run_mode == pulse_seq_pkg::run_duration && elapsed + 32'h1 >= duration;
	wire in_gap    = gap_cnt != 4'h0;
	wire cur_vec_end = vec_cnt + 31'h1 >= vectors[vec_idx].increment;

	// Level of one source at a point in the period, edges ramp linearly
	function automatic logic [31:0] source_level(input pulse_seq_pkg::source_timing_type t,
		input logic [31:0] base, input logic [31:0] peak, input logic [31:0] now);
		logic [31:0] rise_end;
		logic [31:0] fall_start;
		logic [31:0] diff;
		rise_end   = 32'(t.delay) + 32'(t.leading);
		fall_start = rise_end + 32'(t.width);
		diff       = peak - base;
		source_level = base;
		if (now >= 32'(t.delay) && now < rise_end) begin
			source_level = base + 32'((64'(signed'(diff)) * 64'(now - 32'(t.delay))) / 64'(t.leading));
		end else if (now >= rise_end && now < fall_start) begin
			source_level = peak;
		end else if (now >= fall_start && now < fall_start + 32'(t.trailing)) begin
			source_level = peak - 32'((64'(signed'(diff)) * 64'(now - fall_start)) / 64'(t.trailing));
		end
	endfunction

	// Configuration registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_mode    <= 1'b0;
			run_mode       <= 2'h0;
			trig_ch        <= 1'b0;
			trig_en        <= 1'b0;
			out_sw         <= 1'b0;
			period         <= pulse_seq_pkg::period_reset;
			count_limit    <= 32'h0000_0001;
			duration       <= 32'h0000_0001;
			shape          <= '0;
			timing         <= '0;
			base_lvl       <= '0;
			peak_lvl       <= '0;
			sw_enable      <= 1'b0;
			sw_rest_closed <= 1'b0;
			sw_delay       <= 16'h0000;
			sw_hold        <= 16'h0000;
		end else if (write_en) begin
			unique case (paddr)
				pulse_seq_pkg::off_control: begin
					module_mode <= pwdata[pulse_seq_pkg::ctl_module_mode_pos];
					run_mode    <= pwdata[pulse_seq_pkg::ctl_run_mode_pos +: 2];
					trig_ch     <= pwdata[pulse_seq_pkg::ctl_trig_ch_pos];
					trig_en     <= pwdata[pulse_seq_pkg::ctl_trig_en_pos];
					out_sw      <= pwdata[pulse_seq_pkg::ctl_out_sw_pos];
				end
				pulse_seq_pkg::off_period:      period      <= pwdata;
				pulse_seq_pkg::off_count_limit: count_limit <= pwdata;
				pulse_seq_pkg::off_duration:    duration    <= pwdata;
				// Data bits 1:0 shape, bit 4 channel
				pulse_seq_pkg::off_ch_shape:    shape[pwdata[4]] <= pwdata[1:0];
				// Bits 29:0 packed timing fields in a compact form
				pulse_seq_pkg::off_ch_timing: begin
					timing[pwdata[31]][pwdata[30]] <= {2'h0, pwdata[29:16], 2'h0, pwdata[15:2],
						6'h00, pwdata[1:0], 8'h01};
				end
				// Bit 31 channel, bit 30 source, bit 29 peak, 29 low bits level
				pulse_seq_pkg::off_ch_level: begin
					if (pwdata[29])
						peak_lvl[pwdata[31]][pwdata[30]] <= 32'(signed'(pwdata[28:0]));
					else
						base_lvl[pwdata[31]][pwdata[30]] <= 32'(signed'(pwdata[28:0]));
				end
				pulse_seq_pkg::off_switch_cfg: begin
					sw_enable      <= pwdata[0];
					sw_rest_closed <= pwdata[1];
					sw_delay       <= pwdata[17:2];
					sw_hold        <= {2'h0, pwdata[31:18]};
				end
				default: ;
			endcase
		end
	end

	// Pattern and sequence store, one word stream: bit 31 picks table
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_len <= 4'h0;
		end else if (do_seq) begin
			seq_len <= 4'h0;
		end else if (write_en && paddr == pulse_seq_pkg::off_load_data && !pwdata[31] && seq_len != 4'h8) begin
			seq_len <= seq_len + 4'h1;
		end
	end

	always_ff @(posedge pclk) begin
		if (write_en && paddr == pulse_seq_pkg::off_load_data) begin
			if (pwdata[31]) begin
				vectors[pwdata[29:26]] <= {32'(signed'(pwdata[15:8])), pwdata[25], 31'(pwdata[7:0])};
			end else if (seq_len != 4'h8) begin
				steps[seq_len[2:0]] <= {12'h000, pwdata[29:26], 16'h0000, pwdata[15:0]};
			end
		end
	end

	// Load impedance store and measurement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_imp <= '0;
			measured <= 32'h0000_0000;
		end else if (do_meas) begin
			measured <= terminal_level;
			load_imp[pwdata[8]] <= (terminal_level == 32'h0) ? 32'hffff_ffff : 32'(64'd50 * 64'(terminal_level)
				/ 64'(terminal_level));
		end else if (write_en && paddr == pulse_seq_pkg::off_load_imp) begin
			load_imp[pwdata[31]] <= {1'b0, pwdata[30:0]};
		end
	end

	// Run state: set by start, cleared by any stop condition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			rerun   <= 1'b0;
		end else if (wave_cmd) begin
			running <= 1'b0;
			rerun   <= run_mode == pulse_seq_pkg::run_free;
		end else if (rerun) begin
			running <= 1'b1;
			rerun   <= 1'b0;
		end else if (do_stop || count_end || dur_end || sw_off || run_chg) begin
			running <= 1'b0;
		end else if (do_start) begin
			running <= 1'b1;
		end
	end

	// Period, count and duration counters shared by all channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= 32'h0;
			done_cnt   <= 32'h0;
			elapsed    <= 32'h0;
		end else if (!running) begin
			period_cnt <= 32'h0;
			done_cnt   <= 32'h0;
			elapsed    <= 32'h0;
		end else begin
			elapsed    <= elapsed + 32'h1;
			period_cnt <= (period_cnt >= period - 32'h1) ? 32'h0 : period_cnt + 32'h1;
			if (period_cnt >= period - 32'h1)
				done_cnt <= done_cnt + 32'h1;
		end
	end

	// Sequence walker; one shared walk keeps channels in lockstep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_idx <= 3'h0;
			rep_cnt  <= 32'h0;
			vec_idx  <= 4'h0;
			vec_cnt  <= 31'h0;
			gap_cnt  <= 4'h0;
			seq_done <= 1'b0;
		end else if (!running || !module_mode || period_cnt == 32'h0) begin
			step_idx <= 3'h0;
			rep_cnt  <= 32'h0;
			vec_idx  <= steps[0].index[3:0];
			vec_cnt  <= 31'h0;
			gap_cnt  <= 4'h0;
			seq_done <= 1'b0;
		end else if (in_gap) begin
			gap_cnt <= gap_cnt - 4'h1;
		end else if (!seq_done && cur_vec_end) begin
			vec_cnt <= 31'h0;
			if (rep_cnt + 32'h1 < steps[step_idx].repeats) begin
				rep_cnt <= rep_cnt + 32'h1;
			end else if ({1'b0, step_idx} + 4'h1 >= seq_len) begin
				seq_done <= 1'b1;
			end else begin
				step_idx <= step_idx + 3'h1;
				rep_cnt  <= 32'h0;
				vec_idx  <= steps[step_idx + 3'h1].index[3:0];
				if (steps[step_idx + 3'h1].index != steps[step_idx].index)
					gap_cnt <= 4'(pulse_seq_pkg::change_delay_cyc);
			end
		end else if (!seq_done) begin
			vec_cnt <= vec_cnt + 31'h1;
		end
	end

	// Channel levels and switch state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_level       <= '0;
			pulse_switch_closed <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (module_mode) begin
					if (!running)
						channel_level[c] <= vectors[0].level;
					else if (!in_gap)
						channel_level[c] <= vectors[vec_idx].level;
					pulse_switch_closed[c] <= sw_enable && (running ? vectors[vec_idx].switch_closed
						: sw_rest_closed);
				end else begin
					if (!running || shape[c] == pulse_seq_pkg::shape_dc)
						channel_level[c] <= base_lvl[c][0];
					else if (shape[c] == pulse_seq_pkg::shape_src1)
						channel_level[c] <= source_level(timing[c][0], base_lvl[c][0], peak_lvl[c][0], period_cnt);
					else if (shape[c] == pulse_seq_pkg::shape_src2)
						channel_level[c] <= source_level(timing[c][1], base_lvl[c][1], peak_lvl[c][1], period_cnt);
					else
						channel_level[c] <= source_level(timing[c][0], base_lvl[c][0], peak_lvl[c][0], period_cnt)
							+ source_level(timing[c][1], base_lvl[c][1], peak_lvl[c][1], period_cnt);
					pulse_switch_closed[c] <= sw_enable && (running && period_cnt >= 32'(sw_delay)
						&& period_cnt < 32'(sw_delay) + 32'(sw_hold) ? !sw_rest_closed : sw_rest_closed);
				end
			end
		end
	end

	// Trigger pulse: one cycle per qualifying event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_out <= 1'b0;
		end else if (!module_mode) begin
			trigger_out <= trig_en && running && period_cnt == 32'(timing[trig_ch][0].delay);
		end else begin
			// Walker restarts on count zero, so sequence start shows one cycle on
			trigger_out <= trig_en && running && !in_gap && !seq_done
				&& period_cnt != 32'h0 && vec_cnt == 31'h0 && vec_idx == steps[step_idx].index[3:0];
		end
	end

	// APB read path, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					pulse_seq_pkg::off_control:     prdata <= {26'h0, out_sw, trig_en, trig_ch, run_mode, module_mode};
					pulse_seq_pkg::off_period:      prdata <= period;
					pulse_seq_pkg::off_count_limit: prdata <= count_limit;
					pulse_seq_pkg::off_duration:    prdata <= duration;
					pulse_seq_pkg::off_status:      prdata <= {31'h0, running};
					pulse_seq_pkg::off_load_imp:    prdata <= load_imp[0];
					pulse_seq_pkg::off_measure:     prdata <= measured;
					default: pslverr <= paddr > pulse_seq_pkg::off_measure;
				endcase
			end
		end
	end

endmodule

// ===== pkg/pulse_seq_pkg.sv
package pulse_seq_pkg;

	// Register byte offsets
	localparam logic [7:0] off_control     = 8'h00;
	localparam logic [7:0] off_command     = 8'h04;
	localparam logic [7:0] off_period      = 8'h08;
	localparam logic [7:0] off_count_limit = 8'h0c;
	localparam logic [7:0] off_duration    = 8'h10;
	localparam logic [7:0] off_status      = 8'h14;
	localparam logic [7:0] off_ch_shape    = 8'h18;
	localparam logic [7:0] off_ch_timing   = 8'h1c;
	localparam logic [7:0] off_ch_level    = 8'h20;
	localparam logic [7:0] off_switch_cfg  = 8'h24;
	localparam logic [7:0] off_load_data   = 8'h28;
	localparam logic [7:0] off_load_imp    = 8'h2c;
	localparam logic [7:0] off_measure     = 8'h30;

	// Control register fields
	localparam int ctl_module_mode_pos = 0;
	localparam int ctl_run_mode_pos    = 1;
	localparam int ctl_trig_ch_pos     = 3;
	localparam int ctl_trig_en_pos     = 4;
	localparam int ctl_out_sw_pos      = 5;

	// Command register bits (write one to act)
	localparam int cmd_apply_pos  = 0;
	localparam int cmd_start_pos  = 1;
	localparam int cmd_stop_pos   = 2;
	localparam int cmd_seq_pos    = 3;
	localparam int cmd_meas_pos   = 4;

	// Reset values
	localparam logic [31:0] period_reset   = 32'h0000_03e8;
	localparam logic [31:0] control_reset  = 32'h0000_0000;

	// Pattern change setup delay
	localparam int change_delay_ns  = 50;
	localparam int clock_period_ns  = 4;
	localparam int change_delay_cyc = (change_delay_ns + clock_period_ns - 1) / clock_period_ns;

	// Storage sizes
	localparam int vector_depth = 16;
	localparam int seq_depth    = 8;

	typedef enum logic {pulse_mode, waveform_mode} module_mode_type;
	typedef enum logic [1:0] {run_free, run_count, run_duration} run_mode_type;
	typedef enum logic [1:0] {shape_dc, shape_src1, shape_src2, shape_three} shape_type;

	// One source timing in clock cycles
	typedef struct packed {
		logic [15:0] delay;
		logic [15:0] width;
		logic [7:0]  leading;
		logic [7:0]  trailing;
	} source_timing_type;

	// Stored vector: level, switch state, time increment
	typedef struct packed {
		logic [31:0] level;
		logic        switch_closed;
		logic [30:0] increment;
	} vector_type;

	// Sequence step: pattern index and repeat count
	typedef struct packed {
		logic [15:0] index;
		logic [31:0] repeats;
	} seq_step_type;

endpackage

// ===== tb/pulse_and_waveform_sequencer_tb.sv
`timescale 1ns/1ps
`define chk(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t mismatch %h %h", $time, a, b); end end
module pulse_and_waveform_sequencer_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, trigger_out;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [31:0] terminal_level = 32'h0;
	logic [1:0][31:0] channel_level;
	logic [1:0] pulse_switch_closed;
	logic e;
	int error_cnt = 0;
	int check_count = 0;
	int trig_n = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (trigger_out === 1'b1) trig_n++;
	// A transfer that never sees pready ends the run
	always @(posedge host.hang) begin
		error_cnt++;
		$display("ERROR %0t bus transfer timed out", $time);
		complete_run();
	end
	remote_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	pulse_and_waveform_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.terminal_level(terminal_level), .channel_level(channel_level),
		.pulse_switch_closed(pulse_switch_closed), .trigger_out(trigger_out));
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		host.xfer(1'b0, a, 32'h0, d, e);
		`chk(d, x)
	endtask
	// Trigger enabled on channel 0, output switch on
	task automatic ctl(input logic [1:0] r, input logic m);
		host.wr(pulse_seq_pkg::off_control, 32'h30 | {29'h0, r, m});
	endtask
	// Poll status until waiting; a hang ends the run
	task automatic wait_idle(input int polls);
		int n;
		n = 0;
		do begin
			host.xfer(1'b0, pulse_seq_pkg::off_status, 32'h0, d, e);
			n++;
		end while (d[0] !== 1'b0 && n < polls);
		if (d[0] !== 1'b0) begin
			error_cnt++;
			$display("ERROR %0t status stuck running", $time);
			complete_run();
		end
	endtask
	task automatic t_reset();
		`chk(channel_level, 64'h0)
		`chk(trigger_out, 1'b0)
		rd(pulse_seq_pkg::off_period, pulse_seq_pkg::period_reset);
		rd(pulse_seq_pkg::off_control, pulse_seq_pkg::control_reset);
		rd(pulse_seq_pkg::off_status, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 2; m++) begin
			for (int r = 0; r < 3; r++) begin
				ctl(r[1:0], m[0]);
				rd(pulse_seq_pkg::off_control, 32'h30 | {29'h0, r[1:0], m[0]});
			end
		end
		host.wr(pulse_seq_pkg::off_period, 32'h14);
		rd(pulse_seq_pkg::off_period, 32'h14);
		$display("test modes done");
	endtask
	task automatic t_pulse();
		int n;
		ctl(2'h0, 1'b0);
		host.wr(pulse_seq_pkg::off_ch_shape, 32'h1);
		host.wr(pulse_seq_pkg::off_ch_timing, 32'h0004_0009);
		host.wr(pulse_seq_pkg::off_ch_level, 32'h5);
		host.wr(pulse_seq_pkg::off_ch_level, 32'h2000_0009);
		host.wr(pulse_seq_pkg::off_command, 32'h1);
		repeat (3) @(posedge pclk);
		`chk(channel_level[0], 32'h5)
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		rd(pulse_seq_pkg::off_status, 32'h1);
		n = 0;
		while (channel_level[0] !== 32'h9 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		`chk(channel_level[0], 32'h9)
		`chk(trig_n > 0, 1'b1)
		host.wr(pulse_seq_pkg::off_command, 32'h4);
		rd(pulse_seq_pkg::off_status, 32'h0);
		repeat (3) @(posedge pclk);
		`chk(channel_level[0], 32'h5)
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		host.wr(pulse_seq_pkg::off_control, 32'h0);
		wait_idle(4);
		$display("test pulse done");
	endtask
	task automatic t_limits();
		ctl(2'h1, 1'b0);
		host.wr(pulse_seq_pkg::off_count_limit, 32'h2);
		trig_n = 0;
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		wait_idle(200);
		`chk(trig_n, 2)
		ctl(2'h2, 1'b0);
		host.wr(pulse_seq_pkg::off_duration, 32'h3c);
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		rd(pulse_seq_pkg::off_status, 32'h1);
		wait_idle(100);
		$display("test limits done");
	endtask
	task automatic t_wave();
		int n;
		logic sw;
		ctl(2'h0, 1'b1);
		host.wr(pulse_seq_pkg::off_switch_cfg, 32'h1);
		host.wr(pulse_seq_pkg::off_command, 32'h8);
		host.vec(4'h0, 1'b1, 8'h3, 8'h4);
		host.vec(4'h1, 1'b0, 8'h7, 8'h4);
		host.wr(pulse_seq_pkg::off_load_data, 32'h0000_0001);
		host.wr(pulse_seq_pkg::off_load_data, 32'h0400_0001);
		host.wr(pulse_seq_pkg::off_command, 32'h1);
		`chk(channel_level[0], 32'h3)
		trig_n = 0;
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		// Second pattern, then back to the first at the next sequence start
		n = 0;
		while (channel_level[0] !== 32'h7 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (channel_level[0] !== 32'h3 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		// First vector and the change gap both show the first level
		n = 0;
		sw = 1'b0;
		while (channel_level[0] === 32'h3 && n < 300) begin
			sw |= pulse_switch_closed[0];
			@(posedge pclk);
			n++;
		end
		`chk(sw, 1'b1)
		`chk(pulse_switch_closed[0], 1'b0)
		`chk(channel_level[0], 32'h7)
		`chk(n >= 4 + pulse_seq_pkg::change_delay_cyc, 1'b1)
		`chk(trig_n > 0, 1'b1)
		host.wr(pulse_seq_pkg::off_command, 32'h2);
		repeat (2) @(posedge pclk);
		rd(pulse_seq_pkg::off_status, 32'h1);
		host.wr(pulse_seq_pkg::off_command, 32'h4);
		rd(pulse_seq_pkg::off_status, 32'h0);
		`chk(channel_level[0], 32'h3)
		$display("test wave done");
	endtask
	task automatic t_misc();
		terminal_level <= 32'h1234;
		@(posedge pclk);
		host.wr(pulse_seq_pkg::off_command, 32'h10);
		repeat (2) @(posedge pclk);
		rd(pulse_seq_pkg::off_measure, 32'h1234);
		host.wr(8'h38, 32'hffff_ffff);
		rd(8'h34, 32'h0);
		`chk(e, 1'b1)
		`chk(host.hang, 1'b0)
		$display("test misc done");
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_modes();
		t_pulse();
		t_limits();
		t_wave();
		t_misc();
		complete_run();
	end
endmodule

// ===== tb/pulse_seq_checker.sv
`timescale 1ns/1ps
module pulse_seq_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Outputs
	input wire logic [1:0]  pulse_switch_closed,
	input wire logic        trigger_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Wait-free slave: every access phase answers at once
	rdy_access_a: assert property (psel && penable |-> pready) else $error("access without ready");
	rdy_only_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	rdy_pulse_a: assert property (pready |=> !pready) else $error("ready held two cycles");
	err_unmap_a: assert property (psel && penable && !pwrite && paddr > 8'h30 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	err_map_a: assert property (psel && penable && paddr <= 8'h30 |-> !pslverr) else $error("mapped access refused");
	err_write_a: assert property (pslverr |-> !pwrite) else $error("error on a write");
	status_bits_a: assert property (pready && !pwrite && paddr == pulse_seq_pkg::off_status |-> prdata[31:1] == 31'h0)
		else $error("status upper bits set");
	trig_pulse_a: assert property (trigger_out |=> !trigger_out) else $error("trigger wider than one cycle");
	// Main scenarios
	wr_c: cover property (pready && pwrite);
	trig_c: cover property (trigger_out);
	sw_c: cover property (pulse_switch_closed != 2'h0);
endmodule

bind pulse_and_waveform_sequencer pulse_seq_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pulse_switch_closed(pulse_switch_closed), .trigger_out(trigger_out));

// ===== tb/remote_host.sv
`timescale 1ns/1ps
module remote_host (
	// Clock
	input wire logic        pclk,
	// APB master side
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [7:0]      paddr,
	output logic [31:0]     pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic hang = 1'b0;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// One transfer; request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang = 1'b1;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next setup never lands in this time step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask
	// Pattern vector: level, switch state, increment
	task automatic vec(input logic [3:0] i, input logic sw, input logic [7:0] lv, input logic [7:0] inc);
		wr(pulse_seq_pkg::off_load_data, {1'b1, 1'b0, i, sw, 9'h0, lv, inc});
	endtask
endmodule
